// ===== inc/sba_pkg.sv
// Constants and types for the secondary bus arbiter
package sba_pkg;
    localparam int SBA_NUM_REQ = 9;
    localparam int SBA_IDX_W = 4;
    localparam logic [7:0] SBA_REG_OFS = 8'h48;
    // Field positions in the arbitration register
    localparam int SBA_EN_LSB = 0;
    localparam int SBA_EN_MSB = 8;
    localparam int SBA_STRAP_BIT = 9;
    localparam int SBA_BMTO_BIT = 10;
    localparam int SBA_BMRF_BIT = 11;
    localparam int SBA_FAIR_LSB = 12;
    localparam int SBA_FAIR_MSB = 19;
    localparam int SBA_TOG_BIT = 20;
    // Reset values
    localparam logic [8:0] SBA_EN_RST = 9'h1FF;
    localparam logic SBA_BMTO_RST = 1'h0;
    localparam logic SBA_BMRF_RST = 1'h0;
    localparam logic [7:0] SBA_FAIR_RST = 8'h08;
    localparam logic SBA_TOG_RST = 1'h0;
    // Timing counts in bus clocks
    localparam int SBA_BM_CYCLES = 16;
    localparam logic [4:0] SBA_BM_LAST = 5'(SBA_BM_CYCLES - 1);
    localparam int SBA_TOG_DELAY = 2;
    localparam logic [1:0] SBA_TOG_AT = 2'(SBA_TOG_DELAY);
    localparam logic [1:0] SBA_TOG_START = 2'h1;
    localparam logic [7:0] SBA_FAIR_ONE = 8'h01;
    localparam logic [7:0] SBA_FAIR_ZERO = 8'h00;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_WAIT = 3'b010,
        ST_BUSY = 3'b100
    } sba_state_type;
endpackage

// ===== src/sba_arbiter.sv
// Secondary bus arbiter with enables, broken-master and fairness logic
//
// Functional notes
// - Internal request arbitrated only while bit 0 set
// - Bits 1..8 gate external masters, reset 1
// - Bit 9 reads arbiter select strap level
// - Bit 10 enables 16-cycle idle-bus timeout count
// - Timeout expiry removes grant from broken master
// - Refresh off: broken master ignored after releasing
// - Refresh on: clear broken after others served
// - Bits 19:12 hold fairness count, reset 08h
// - Counter reloaded per grant, armed at FRAME fall
// - Fairness zero: hold grant until request drops
// - Bit 20: grant drops 1 clock, 2 after FRAME
module sba_arbiter
    import sba_pkg::*;
(
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic int_req_in,
    input wire logic [8:1] req_l_in,
    input wire logic frame_l_in,
    input wire logic irdy_l_in,
    input wire logic arbiter_select_strap_in,
    input wire logic cfg_wr_in,
    input wire logic cfg_rd_in,
    input wire logic [7:0] cfg_addr_in,
    input wire logic [3:0] cfg_be_in,
    input wire logic [31:0] cfg_wdata_in,
    output logic int_gnt_out,
    output logic [8:1] gnt_l_out,
    output logic [31:0] cfg_rdata_out
);
    // Pin synchronisers
    logic [8:1] req_m_q, req_s_q;
    logic frame_m_q, frame_s_q, frame_p_q, irdy_m_q, irdy_s_q;
    logic strap_m_q, strap_s_q;

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            req_m_q <= 8'hFF;
            req_s_q <= 8'hFF;
            frame_m_q <= 1'h1;
            frame_s_q <= 1'h1;
            frame_p_q <= 1'h1;
            irdy_m_q <= 1'h1;
            irdy_s_q <= 1'h1;
            strap_m_q <= 1'h0;
            strap_s_q <= 1'h0;
        end
        else
        begin
            req_m_q <= req_l_in;
            req_s_q <= req_m_q;
            frame_m_q <= frame_l_in;
            frame_s_q <= frame_m_q;
            frame_p_q <= frame_s_q;
            irdy_m_q <= irdy_l_in;
            irdy_s_q <= irdy_m_q;
            strap_m_q <= arbiter_select_strap_in;
            strap_s_q <= strap_m_q;
        end
    end

    // Register state
    logic [8:0] en_q, en_d;
    logic bmto_q, bmto_d, bmrf_q, bmrf_d, tog_en_q, tog_en_d;
    logic strap_q, strap_d;
    logic [7:0] fair_ld_q, fair_ld_d;
    logic [31:0] rdata_q, rdata_d, cur_reg, wmask, new_reg;
    logic reg_hit;

    always_comb
    begin
        cur_reg = 32'h0;
        cur_reg[SBA_EN_MSB:SBA_EN_LSB] = en_q;
        cur_reg[SBA_STRAP_BIT] = strap_q;
        cur_reg[SBA_BMTO_BIT] = bmto_q;
        cur_reg[SBA_BMRF_BIT] = bmrf_q;
        cur_reg[SBA_FAIR_MSB:SBA_FAIR_LSB] = fair_ld_q;
        cur_reg[SBA_TOG_BIT] = tog_en_q;
        wmask = {{8{cfg_be_in[3]}}, {8{cfg_be_in[2]}},
                 {8{cfg_be_in[1]}}, {8{cfg_be_in[0]}}};
        new_reg = (cur_reg & ~wmask) | (cfg_wdata_in & wmask);
        reg_hit = (cfg_addr_in == SBA_REG_OFS);
        en_d = en_q;
        bmto_d = bmto_q;
        bmrf_d = bmrf_q;
        fair_ld_d = fair_ld_q;
        tog_en_d = tog_en_q;
        strap_d = strap_s_q;
        rdata_d = rdata_q;
        if (cfg_wr_in && reg_hit)
        begin
            en_d = new_reg[SBA_EN_MSB:SBA_EN_LSB];
            bmto_d = new_reg[SBA_BMTO_BIT];
            bmrf_d = new_reg[SBA_BMRF_BIT];
            fair_ld_d = new_reg[SBA_FAIR_MSB:SBA_FAIR_LSB];
            tog_en_d = new_reg[SBA_TOG_BIT];
        end
        if (cfg_rd_in)
        begin
            rdata_d = reg_hit ? cur_reg : 32'h0;
        end
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            en_q <= SBA_EN_RST;
            bmto_q <= SBA_BMTO_RST;
            bmrf_q <= SBA_BMRF_RST;
            fair_ld_q <= SBA_FAIR_RST;
            tog_en_q <= SBA_TOG_RST;
            strap_q <= 1'h0;
            rdata_q <= 32'h0;
        end
        else
        begin
            en_q <= en_d;
            bmto_q <= bmto_d;
            bmrf_q <= bmrf_d;
            fair_ld_q <= fair_ld_d;
            tog_en_q <= tog_en_d;
            strap_q <= strap_d;
            rdata_q <= rdata_d;
        end
    end

    // Round robin pick starting after the last owner
    function automatic logic [3:0] pick(input logic [8:0] elig,
                                        input logic [3:0] last);
        int idx;
        logic [3:0] res;
        res = last;
        for (int k = SBA_NUM_REQ; k >= 1; k--)
        begin
            idx = (int'(last) + k) % SBA_NUM_REQ;
            if (elig[idx])
            begin
                res = SBA_IDX_W'(idx);
            end
        end
        return res;
    endfunction

    // Arbitration state
    sba_state_type st_q, st_d;
    logic [3:0] own_q, own_d;
    logic [4:0] bm_cnt_q, bm_cnt_d;
    logic [7:0] fair_q, fair_d;
    logic armed_q, armed_d;
    logic [1:0] tog_cnt_q, tog_cnt_d;
    logic [8:0] broken_q, broken_d, ignored_q, ignored_d;
    logic [8:0] served_q, served_d, gnt_q, gnt_d;
    logic [8:0] req, elig, own_oh;
    logic frame_fall, bus_idle, owner_live, others_wait, fair_dec;
    logic bm_hit;

    always_comb
    begin
        req = {~req_s_q, int_req_in};
        elig = req & en_q & ~ignored_q;
        own_oh = 9'h001 << own_q;
        frame_fall = frame_p_q && !frame_s_q;
        bus_idle = frame_s_q && irdy_s_q;
        owner_live = |(own_oh & req & en_q);
        others_wait = |(elig & ~own_oh);
        fair_dec = (st_q == ST_BUSY) && armed_q && others_wait
                   && (fair_ld_q != SBA_FAIR_ZERO) && owner_live;
        st_d = st_q;
        own_d = own_q;
        bm_cnt_d = bm_cnt_q;
        fair_d = fair_q;
        armed_d = armed_q;
        tog_cnt_d = (tog_cnt_q == 2'h0 || tog_cnt_q == SBA_TOG_AT)
                    ? 2'h0 : tog_cnt_q + 2'h1;
        broken_d = broken_q;
        ignored_d = ignored_q | (broken_q & ~req);
        served_d = served_q;
        bm_hit = 1'h0;
        case (st_q)
            ST_IDLE:
            begin
                if (!strap_q && |elig)
                begin
                    own_d = pick(elig, own_q);
                    st_d = ST_WAIT;
                    fair_d = fair_ld_q;
                    armed_d = 1'h0;
                    bm_cnt_d = 5'h0;
                    served_d = served_q | (9'h001 << own_d);
                end
            end
            ST_WAIT:
            begin
                if (!owner_live || strap_q)
                begin
                    st_d = ST_IDLE;
                end
                else if (frame_fall)
                begin
                    st_d = ST_BUSY;
                    armed_d = 1'h1;
                    if (tog_en_q)
                    begin
                        tog_cnt_d = SBA_TOG_START;
                    end
                end
                else if (bmto_q && bus_idle)
                begin
                    bm_cnt_d = bm_cnt_q + 5'h1;
                    if (bm_cnt_q == SBA_BM_LAST)
                    begin
                        st_d = ST_IDLE;
                        broken_d = broken_q | own_oh;
                        bm_hit = 1'h1;
                        // Service history restarts when a master breaks
                        served_d = 9'h0;
                    end
                end
            end
            ST_BUSY:
            begin
                if (!owner_live || strap_q)
                begin
                    st_d = ST_IDLE;
                end
                else if (fair_dec)
                begin
                    fair_d = fair_q - SBA_FAIR_ONE;
                    if (fair_q == SBA_FAIR_ONE)
                    begin
                        st_d = ST_IDLE;
                    end
                end
            end
            default:
            begin
                st_d = ST_IDLE;
            end
        endcase
        // Refresh once every other enabled requestor has been served
        if (bmrf_q)
        begin
            for (int i = 0; i < SBA_NUM_REQ; i++)
            begin
                // A fresh timeout wins over a refresh in the same cycle
                if (broken_q[i] && !(bm_hit && own_oh[i])
                    && &(served_q | ~en_q | (9'h001 << i)))
                begin
                    broken_d[i] = 1'h0;
                    ignored_d[i] = 1'h0;
                    served_d = (st_q == ST_IDLE && st_d == ST_WAIT)
                               ? (9'h001 << own_d) : 9'h0;
                end
            end
        end
        gnt_d = (st_d != ST_IDLE && tog_cnt_q != SBA_TOG_AT)
                ? (9'h001 << own_d) : 9'h0;
    end

    always_ff @(posedge sys_clk_in or negedge rst_b_in)
    begin
        if (!rst_b_in)
        begin
            st_q <= ST_IDLE;
            own_q <= 4'h0;
            bm_cnt_q <= 5'h0;
            fair_q <= SBA_FAIR_RST;
            armed_q <= 1'h0;
            tog_cnt_q <= 2'h0;
            broken_q <= 9'h0;
            ignored_q <= 9'h0;
            served_q <= 9'h0;
            gnt_q <= 9'h0;
        end
        else
        begin
            st_q <= st_d;
            own_q <= own_d;
            bm_cnt_q <= bm_cnt_d;
            fair_q <= fair_d;
            armed_q <= armed_d;
            tog_cnt_q <= tog_cnt_d;
            broken_q <= broken_d;
            ignored_q <= ignored_d;
            served_q <= served_d;
            gnt_q <= gnt_d;
        end
    end

    assign int_gnt_out = gnt_q[0];
    assign gnt_l_out = ~gnt_q[8:1];
    assign cfg_rdata_out = rdata_q;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (!rst_b_in);

    a_int_gate: assert property (
        (gnt_q[0] && !$past(gnt_q[0]))
        |-> $past(en_q[0]) && $past(int_req_in))
        else $error("internal grant while disabled");
    a_ext_gate: assert property (
        ((gnt_q[8:1] & ~$past(gnt_q[8:1])) & ~$past(en_q[8:1])) == 8'h0)
        else $error("external grant while disabled");
    a_strap_hold: assert property (
        strap_q && $past(strap_q) |-> st_q == ST_IDLE)
        else $error("grant with external arbiter");
    a_bm_expire: assert property (
        (st_q == ST_WAIT && bmto_q && bus_idle && owner_live && !frame_fall
         && !strap_q && bm_cnt_q == SBA_BM_LAST)
        |=> st_q == ST_IDLE && |(broken_q & $past(own_oh)))
        else $error("timeout did not remove grant");
    a_ignore_grant: assert property (
        (st_q == ST_IDLE && st_d == ST_WAIT) |-> !ignored_q[own_d])
        else $error("ignored master granted");
    a_fair_reload: assert property (
        (st_q == ST_WAIT && $past(st_q) == ST_IDLE)
        |-> fair_q == $past(fair_ld_q) && !armed_q)
        else $error("fairness not reloaded");
    a_fair_zero: assert property (
        (st_q == ST_BUSY && fair_ld_q == SBA_FAIR_ZERO && owner_live
         && !strap_q) |=> st_q == ST_BUSY)
        else $error("grant removed with zero fairness");
    a_tog_drop: assert property (
        (st_q == ST_WAIT && frame_fall && tog_en_q && owner_live && !strap_q)
        |-> ##2 (tog_cnt_q == SBA_TOG_AT) ##1 (gnt_q == 9'h0))
        else $error("grant toggle timing wrong");
    a_fair_count: assert property (
        (fair_dec && fair_q > SBA_FAIR_ONE && !strap_q)
        |=> fair_q == $past(fair_q) - SBA_FAIR_ONE && st_q == ST_BUSY)
        else $error("fairness did not count");
    a_fair_expire: assert property (
        (fair_dec && fair_q == SBA_FAIR_ONE)
        |=> st_q == ST_IDLE ##1 gnt_q != $past(gnt_q, 2) || gnt_q == 9'h0)
        else $error("grant kept after fairness expiry");
endmodule // sba_arbiter

// ===== verif/sba_masters.sv
// External bus masters facing the secondary bus arbiter
module sba_masters (
    input wire logic sys_clk_in,
    input wire logic rst_b_in,
    input wire logic [8:1] gnt_l_in,
    input wire logic [8:1] want_in,
    input wire logic [8:1] dead_in,
    output logic [8:1] req_l_out,
    output logic frame_l_out,
    output logic irdy_l_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [2:0] cnt_q;
    // Granted live master runs repeated 3-cycle frames with FRAME high 3 clocks between
    always_ff @(posedge sys_clk_in or negedge rst_b_in)
        if (!rst_b_in)
            cnt_q <= 3'h0;
        else if (cnt_q != 3'h0)
            cnt_q <= cnt_q - 3'h1;
        else if (|(~gnt_l_in & want_in & ~dead_in))
            cnt_q <= 3'h5;
    assign req_l_out = ~want_in;
    assign frame_l_out = !(cnt_q > 3'h2);
    assign irdy_l_out = !(cnt_q > 3'h1);
endmodule // sba_masters

// ===== verif/sba_arbiter_tb.sv
// Self-checking testbench for the secondary bus arbiter
module sba_arbiter_tb;
    import sba_pkg::*;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst_b, int_req, strap, wr, rd, int_gnt;
    logic [8:1] want, dead, req_l, gnt_l;
    logic frame_l, irdy_l;
    logic [7:0] addr;
    logic [3:0] be;
    logic [31:0] wdata, rdata, d;
    int n_errors = 0;
    int n_tests = 0;
    int n, k, n3;
    wire logic [8:0] gv = {~gnt_l, int_gnt};

    sba_arbiter i_dut (.sys_clk_in(clk), .rst_b_in(rst_b),
        .int_req_in(int_req), .req_l_in(req_l), .frame_l_in(frame_l),
        .irdy_l_in(irdy_l), .arbiter_select_strap_in(strap),
        .cfg_wr_in(wr), .cfg_rd_in(rd), .cfg_addr_in(addr),
        .cfg_be_in(be), .cfg_wdata_in(wdata), .int_gnt_out(int_gnt),
        .gnt_l_out(gnt_l), .cfg_rdata_out(rdata));
    sba_masters i_masters (.sys_clk_in(clk), .rst_b_in(rst_b),
        .gnt_l_in(gnt_l), .want_in(want), .dead_in(dead),
        .req_l_out(req_l), .frame_l_out(frame_l), .irdy_l_out(irdy_l));

    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic results();
        $display("tests %0d errors %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] e,
                       input logic [31:0] g);
        n_tests++;
        if (g !== e)
        begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, e, g);
        end
    endtask

    task automatic cyc(input int c);
        repeat (c) @(posedge clk);
    endtask

    task automatic do_rst();
        rst_b <= 1'b0;
        int_req <= 1'b0;
        want <= 8'h00;
        dead <= 8'h00;
        cyc(5);
        rst_b <= 1'b1;
        cyc(3);
    endtask

    task automatic wr_at(input logic [7:0] a, input logic [31:0] v);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= v;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    task automatic rd_at(input logic [7:0] a, output logic [31:0] v);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        @(posedge clk);
        v = rdata;
    endtask

    task automatic rq(input int i, input logic v);
        if (i == 0)
            int_req <= v;
        else
            want[i] <= v;
    endtask

    task automatic wt(input int i, input int lim, output int c);
        c = 0;
        while (gv[i] !== 1'b1 && c < lim)
        begin
            @(posedge clk);
            c++;
        end
        chk("grant", 1, gv[i]);
    endtask

    task automatic hold(input int i, input int lim, output int c);
        c = 0;
        while (gv[i] === 1'b1 && c < lim)
        begin
            @(posedge clk);
            c++;
        end
    endtask

    task automatic t_regs();
        rd_at(8'h48, d);
        chk("reset value", 32'h0000_81FF, d);
        be <= 4'h2;
        wr_at(8'h48, 32'h0);
        be <= 4'hF;
        rd_at(8'h48, d);
        chk("byte lane write", 32'h0000_00FF, d);
        wr_at(8'h48, 32'h0000_81FF);
        wr_at(8'h44, 32'h0);
        rd_at(8'h44, d);
        chk("unmapped read", 32'h0, d);
        strap <= 1'b1;
        cyc(4);
        rq(1, 1'b1);
        cyc(8);
        rd_at(8'h48, d);
        chk("strap bit", 32'h0000_83FF, d);
        chk("grants strap high", 32'h0, gv);
        strap <= 1'b0;
        wt(1, 12, n);
        rq(1, 1'b0);
        cyc(8);
    endtask

    task automatic t_enables();
        for (int i = 0; i < 9; i++)
        begin
            wr_at(8'h48, 32'h0000_8000 | (32'h1FF & ~(32'h1 << i)));
            rq(i, 1'b1);
            cyc(12);
            chk("disabled grant", 0, gv[i]);
            wr_at(8'h48, 32'h0000_81FF);
            wt(i, 12, n);
            rq(i, 1'b0);
            cyc(8);
        end
    endtask

    task automatic t_broken();
        wr_at(8'h48, 32'h0000_8412);
        dead <= 8'h08;
        rq(4, 1'b1);
        wt(4, 12, n);
        hold(4, 40, n);
        chk("timeout span", 1, n >= 16 && n <= 18);
        rq(4, 1'b0);
        cyc(4);
        rq(4, 1'b1);
        cyc(30);
        chk("broken ignored", 0, gv[4]);
        wr_at(8'h48, 32'h0000_8C12);
        cyc(8);
        chk("refresh waits", 0, gv[4]);
        rq(1, 1'b1);
        wt(1, 12, n);
        rq(1, 1'b0);
        wt(4, 40, n);
        do_rst();
    endtask

    task automatic t_fair(input logic [7:0] f, output int c);
        wr_at(8'h48, {12'h0, f, 12'h1FF});
        rq(1, 1'b1);
        wt(1, 12, c);
        cyc(6);
        rq(2, 1'b1);
        hold(1, 80, c);
        if (f == 8'h00)
            rq(1, 1'b0);
        wt(2, 12, k);
        do_rst();
    endtask

    task automatic t_toggle();
        wr_at(8'h48, 32'h0010_81FF);
        rq(5, 1'b1);
        wt(5, 12, n);
        k = 0;
        repeat (9)
        begin
            @(posedge clk);
            k += (gv[5] === 1'b0);
        end
        chk("toggle drops", 1, k);
        do_rst();
    endtask

    initial
    begin
        #(25 * 20000);
        n_errors++;
        results();
    end

    initial
    begin
        rst_b = 1'b0;
        int_req = 1'b0;
        want = 8'h00;
        dead = 8'h00;
        strap = 1'b0;
        wr = 1'b0;
        rd = 1'b0;
        addr = 8'h00;
        wdata = 32'h0;
        be = 4'hF;
        do_rst();
        t_regs();
        t_enables();
        t_broken();
        t_fair(8'h03, n3);
        t_fair(8'h08, n);
        chk("fairness step", 5, n - n3);
        t_fair(8'h00, n);
        chk("fair zero hold", 80, n);
        t_toggle();
        results();
    end
endmodule // sba_arbiter_tb
